//--- rtl/ric_pkg.sv
// Purpose: Shared constants and helpers of the reader interrupt controller.
// Assumes: Registers are 8 bits wide on a plain strobe port.
// Notes: Flag and enable registers use bit 7 as the set or clear selector.
package ric_pkg;
	localparam int RIC_DW = 8;
	localparam int RIC_AW = 4;
	localparam int RIC_FW = 7;
	localparam int RIC_NBANK = 4;
	// ==========================================================
	// Register offsets
	localparam logic [RIC_AW-1:0] OFS_FLAGS_A = 4'h0;
	localparam logic [RIC_AW-1:0] OFS_FLAGS_B = 4'h1;
	localparam logic [RIC_AW-1:0] OFS_ENABLE_A = 4'h2;
	localparam logic [RIC_AW-1:0] OFS_ENABLE_B = 4'h3;
	localparam logic [RIC_AW-1:0] OFS_STATUS = 4'h4;
	localparam logic [RIC_AW-1:0] OFS_CTRL = 4'h5;
	localparam logic [RIC_AW-1:0] OFS_LEVEL = 4'h6;
	// ==========================================================
	// Field positions
	localparam int SETCLR_BIT = 7;
	localparam int FA_RX_SOF = 0;
	localparam int FA_COMM_ERROR = 1;
	localparam int FA_RX_DONE = 2;
	localparam int FA_TX_DONE = 3;
	localparam int FA_COMMAND_DONE = 4;
	localparam int FA_FIFO_LOW = 5;
	localparam int FA_FIFO_HIGH = 6;
	localparam int FB_TIMER0 = 0;
	localparam int FB_NTIMER = 4;
	localparam int FB_CARD_DETECT = 4;
	localparam int FB_ANY_SOURCE = 6;
	localparam int ST_IRQ_BIT = 0;
	localparam int CTRL_PIN_EN_BIT = 0;
	// ==========================================================
	// Reset values and codes
	localparam logic [RIC_FW-1:0] FLAGS_RST = 7'h00;
	localparam logic [RIC_DW-1:0] CTRL_RST = 8'h00;
	localparam logic [RIC_DW-1:0] LEVEL_RST = 8'h08;
	localparam logic [RIC_DW-1:0] RDATA_ZERO = 8'h00;
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef enum logic [1:0] {
		RIC_ACC_NONE = 2'b00,
		RIC_ACC_WRITE = 2'b01,
		RIC_ACC_READ = 2'b10
	} ric_acc_t;

	// ==========================================================
	// Address match used by both the write and read decoders.
	function automatic logic ric_hit(input logic [RIC_AW-1:0] a, input logic [RIC_AW-1:0] o);
		ric_hit = (a == o);
	endfunction
endpackage

//--- rtl/ric_bank_if.sv
// Purpose: Carries one set or clear register between the top and its bank.
// Assumes: Single clock domain.
// Notes: hw_set wins over a software clear in the same cycle.
`timescale 1ns/1ps
interface ric_bank_if;
	logic wr;
	logic [7:0] wdata;
	logic [6:0] hw_set;
	logic [6:0] q;
	modport ctl (output wr, output wdata, output hw_set, input q);
	modport bank (input wr, input wdata, input hw_set, output q);
endinterface

//--- rtl/ric_setclr_reg.sv
// Purpose: Seven bit register written through the bit 7 set or clear selector.
// Assumes: Strobe comes from logic on the same clock.
// Notes: Hardware set has priority over a software clear.
`timescale 1ns/1ps
module ric_setclr_reg
	import ric_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	ric_bank_if.bank b
);
	typedef struct packed {
		logic [RIC_FW-1:0] q;
	} ric_scr_t;

	ric_scr_t st_r;
	ric_scr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (b.wr) begin
			if (b.wdata[SETCLR_BIT]) begin
				st_nxt.q = st_r.q | b.wdata[RIC_FW-1:0];
			end else begin
				st_nxt.q = st_r.q & ~b.wdata[RIC_FW-1:0];
			end
		end
		st_nxt.q = st_nxt.q | b.hw_set;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{q: FLAGS_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign b.q = st_r.q;
endmodule // ric_setclr_reg

//--- rtl/ric_evt_src.sv
// Purpose: Turns raw source conditions into per cycle flag set requests.
// Assumes: All inputs come from logic on the same clock.
// Notes: Level sources request a set in every cycle their condition holds.
`timescale 1ns/1ps
module ric_evt_src
	import ric_pkg::*;
#(
	parameter int FIFO_DEPTH = 512,
	parameter int CNT_W = 10
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] timer_underflow,
	input wire logic tx_end,
	input wire logic rx_end,
	input wire logic rx_sof,
	input wire logic card_detect,
	input wire logic [7:0] comm_error_bits,
	input wire logic [3:0] cmd_code,
	input wire logic [CNT_W-1:0] fifo_count,
	input wire logic [7:0] fifo_threshold_level,
	output logic [6:0] ev_a,
	output logic [6:0] ev_b
);
	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);

	typedef struct packed {
		logic was_idle;
	} ric_evs_t;

	ric_evs_t st_r;
	ric_evs_t st_nxt;
	logic [CNT_W-1:0] lvl;

	always_comb begin
		st_nxt = st_r;
		st_nxt.was_idle = (cmd_code == CMD_IDLE);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{was_idle: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign lvl = CNT_W'(fifo_threshold_level);

	always_comb begin
		ev_a = '0;
		ev_b = '0;
		ev_a[FA_RX_SOF] = rx_sof;
		ev_a[FA_COMM_ERROR] = |comm_error_bits;
		ev_a[FA_RX_DONE] = rx_end;
		ev_a[FA_TX_DONE] = tx_end;
		ev_a[FA_COMMAND_DONE] = !st_r.was_idle && (cmd_code == CMD_IDLE);
		ev_a[FA_FIFO_HIGH] = fifo_count >= (DEPTH_C - lvl);
		ev_a[FA_FIFO_LOW] = fifo_count <= lvl;
		ev_b[FB_TIMER0 +: FB_NTIMER] = timer_underflow;
		ev_b[FB_CARD_DETECT] = card_detect;
	end
endmodule // ric_evt_src

//--- rtl/ric_top.sv
// Purpose: Interrupt controller of a contactless reader frontend.
// Assumes: Event sources and the register port run on clock.
// Notes: Registers sit at the offsets in ric_pkg, read data follow one cycle later.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ric_top
	import ric_pkg::*;
#(
	parameter int FIFO_DEPTH = 512,
	parameter int CNT_W = 10
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [RIC_AW-1:0] reg_addr,
	input wire logic [RIC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [RIC_DW-1:0] reg_rdata,
	input wire logic [3:0] timer_underflow,
	input wire logic tx_end,
	input wire logic rx_end,
	input wire logic rx_sof,
	input wire logic card_detect,
	input wire logic [7:0] comm_error_bits,
	input wire logic [3:0] cmd_code,
	input wire logic [CNT_W-1:0] fifo_count,
	output logic irq_pin
);
	// ==========================================================
	// Reset release
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= SYNC_RST;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	// ==========================================================
	// State
	typedef struct packed {
		logic [RIC_DW-1:0] rdata;
		logic irq;
		logic summary;
		logic [RIC_DW-1:0] ctrl;
		logic [RIC_DW-1:0] level;
	} ric_top_t;

	ric_top_t st_r;
	ric_top_t st_nxt;

	// ==========================================================
	// Flag and enable banks
	ric_bank_if bif [RIC_NBANK] ();
	logic [RIC_NBANK-1:0] bank_wr;
	logic [RIC_AW-1:0] bank_ofs [RIC_NBANK];
	logic [6:0] bank_hw [RIC_NBANK];
	logic [6:0] ev_a;
	logic [6:0] ev_b;
	logic [6:0] flags_a;
	logic [6:0] flags_b;
	logic [6:0] en_a;
	logic [6:0] en_b;
	logic any_other;
	logic pending;
	ric_acc_t acc;

	assign bank_ofs[0] = OFS_FLAGS_A;
	assign bank_ofs[1] = OFS_FLAGS_B;
	assign bank_ofs[2] = OFS_ENABLE_A;
	assign bank_ofs[3] = OFS_ENABLE_B;

	always_comb begin
		if (reg_wr) begin
			acc = RIC_ACC_WRITE;
		end else if (reg_rd) begin
			acc = RIC_ACC_READ;
		end else begin
			acc = RIC_ACC_NONE;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < RIC_NBANK; gi++) begin : g_bank
			assign bank_wr[gi] = (acc == RIC_ACC_WRITE) && ric_hit(reg_addr, bank_ofs[gi]);
			assign bif[gi].wr = bank_wr[gi];
			assign bif[gi].wdata = reg_wdata;
			assign bif[gi].hw_set = bank_hw[gi];
			ric_setclr_reg u_reg (
				.clock(clock),
				.rst_n(rst_n),
				.b(bif[gi])
			);
		end
	endgenerate

	assign flags_a = bif[0].q;
	assign flags_b = bif[1].q;
	assign en_a = bif[2].q;
	assign en_b = bif[3].q;

	// ==========================================================
	// Event sources
	ric_evt_src #(
		.FIFO_DEPTH(FIFO_DEPTH),
		.CNT_W(CNT_W)
	) u_src (
		.clock(clock),
		.rst_n(rst_n),
		.timer_underflow(timer_underflow),
		.tx_end(tx_end),
		.rx_end(rx_end),
		.rx_sof(rx_sof),
		.card_detect(card_detect),
		.comm_error_bits(comm_error_bits),
		.cmd_code(cmd_code),
		.fifo_count(fifo_count),
		.fifo_threshold_level(st_r.level),
		.ev_a(ev_a),
		.ev_b(ev_b)
	);

	always_comb begin
		logic [6:0] others_b;
		others_b = flags_b & en_b;
		others_b[FB_ANY_SOURCE] = 1'b0;
		any_other = |(flags_a & en_a) || |others_b;
	end

	always_comb begin
		bank_hw[0] = ev_a;
		bank_hw[1] = ev_b;
		bank_hw[1][FB_ANY_SOURCE] = any_other;
		bank_hw[2] = '0;
		bank_hw[3] = '0;
	end

	assign pending = |(flags_a & en_a) || |(flags_b & en_b);

	// ==========================================================
	// Register port, summary and pin
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = RDATA_ZERO;
		st_nxt.summary = pending;
		st_nxt.irq = pending && st_r.ctrl[CTRL_PIN_EN_BIT];
		if (acc == RIC_ACC_WRITE) begin
			if (ric_hit(reg_addr, OFS_CTRL)) begin
				st_nxt.ctrl = reg_wdata;
			end else if (ric_hit(reg_addr, OFS_LEVEL)) begin
				st_nxt.level = reg_wdata;
			end
		end else if (acc == RIC_ACC_READ) begin
			if (ric_hit(reg_addr, OFS_FLAGS_A)) begin
				st_nxt.rdata = {1'b0, flags_a};
			end else if (ric_hit(reg_addr, OFS_FLAGS_B)) begin
				st_nxt.rdata = {1'b0, flags_b};
			end else if (ric_hit(reg_addr, OFS_ENABLE_A)) begin
				st_nxt.rdata = {1'b0, en_a};
			end else if (ric_hit(reg_addr, OFS_ENABLE_B)) begin
				st_nxt.rdata = {1'b0, en_b};
			end else if (ric_hit(reg_addr, OFS_STATUS)) begin
				st_nxt.rdata[ST_IRQ_BIT] = st_r.summary;
			end else if (ric_hit(reg_addr, OFS_CTRL)) begin
				st_nxt.rdata = st_r.ctrl;
			end else if (ric_hit(reg_addr, OFS_LEVEL)) begin
				st_nxt.rdata = st_r.level;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{rdata: RDATA_ZERO, irq: 1'b0, summary: 1'b0,
				ctrl: CTRL_RST, level: LEVEL_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign irq_pin = st_r.irq;
endmodule // ric_top

//--- bench/ric_host_mdl.sv
// Purpose: Host side model that watches the interrupt request pin.
// Assumes: The pin is a level output on the system clock.
// Notes: Counts each rise of the pin as one interrupt taken.
`timescale 1ns/1ps
module ric_host_mdl (
	input wire logic clock,
	input wire logic irq_pin,
	output logic [7:0] irq_count
);
	// ==========
	// Interrupt intake
	logic seen_r = 1'b0;
	logic [7:0] count_r = 8'h00;
	assign irq_count = count_r;
	always @(posedge clock) begin
		seen_r <= (irq_pin === 1'b1);
		if (irq_pin === 1'b1 && !seen_r) count_r <= count_r + 8'h01;
	end
endmodule // ric_host_mdl

//--- bench/ric_sva.sv
// Purpose: Port checks of the interrupt controller.
// Assumes: No register access until three edges after reset release.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module ric_sva
	import ric_pkg::*;
#(
	parameter int FIFO_DEPTH = 512,
	parameter int CNT_W = 10
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [RIC_AW-1:0] reg_addr,
	input wire logic [RIC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [RIC_DW-1:0] reg_rdata,
	input wire logic [3:0] timer_underflow,
	input wire logic tx_end,
	input wire logic rx_end,
	input wire logic rx_sof,
	input wire logic card_detect,
	input wire logic [7:0] comm_error_bits,
	input wire logic [3:0] cmd_code,
	input wire logic [CNT_W-1:0] fifo_count,
	input wire logic irq_pin
);
	// ==========
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_rd(a); reg_rd && !reg_wr && reg_addr == a; endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == RDATA_ZERO; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_unmapped; reg_rd && !reg_wr && reg_addr > OFS_LEVEL |=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_bit7; reg_rd && reg_addr <= OFS_ENABLE_B |=> !reg_rdata[SETCLR_BIT]; endproperty
	a_bit7: assert property (p_bit7) else $error("selector bit read as one");
	property p_en_set;
		reg_wr && reg_addr == OFS_ENABLE_A && reg_wdata == 8'hFF ##1 s_rd(OFS_ENABLE_A)
		|=> reg_rdata == 8'h7F;
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set lost");
	property p_timer;
		(|timer_underflow) ##1 s_rd(OFS_FLAGS_B)
		|=> (reg_rdata[3:0] & $past(timer_underflow, 2)) == $past(timer_underflow, 2);
	endproperty
	a_timer: assert property (p_timer) else $error("timer flag missing");
	property p_err; (|comm_error_bits) ##1 s_rd(OFS_FLAGS_A) |=> reg_rdata[FA_COMM_ERROR]; endproperty
	a_err: assert property (p_err) else $error("error flag missing");
	property p_idle;
		cmd_code != CMD_IDLE ##1 cmd_code == CMD_IDLE ##1 s_rd(OFS_FLAGS_A)
		|=> reg_rdata[FA_COMMAND_DONE];
	endproperty
	a_idle: assert property (p_idle) else $error("command done flag missing");
	property p_pin_off; reg_wr && reg_addr == OFS_CTRL && !reg_wdata[0] |=> ##1 !irq_pin; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin high while off");
	property p_pin_st; irq_pin and s_rd(OFS_STATUS) |=> reg_rdata[ST_IRQ_BIT]; endproperty
	a_pin_st: assert property (p_pin_st) else $error("pin without summary");
	c_pin: cover property (irq_pin);
	c_status: cover property (s_rd(OFS_STATUS));
	c_timer: cover property (|timer_underflow);
endmodule // ric_sva
bind ric_top ric_sva #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_sva (.clock(clock),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_underflow(timer_underflow),
	.tx_end(tx_end), .rx_end(rx_end), .rx_sof(rx_sof), .card_detect(card_detect),
	.comm_error_bits(comm_error_bits), .cmd_code(cmd_code), .fifo_count(fifo_count),
	.irq_pin(irq_pin));

//--- bench/tb_top.sv
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Default FIFO depth and reset water level.
// Notes: Random data come from a fixed seed.
`timescale 1ns/1ps
module tb_top;
	import ric_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [3:0] timer_underflow = 4'h0;
	logic [3:0] cmd_code = 4'h0;
	logic [3:0] misc = 4'h0;
	logic [7:0] comm_error_bits = 8'h00;
	logic [9:0] fifo_count = 10'h064;
	logic irq_pin;
	logic [7:0] hits;
	logic [31:0] seed = 32'h192DBC86;
	logic [7:0] en [2];
	int mismatches = 0;
	int checked = 0;
	always #10 clock = ~clock;
	ric_top #(.FIFO_DEPTH(512), .CNT_W(10)) DUT (.clock(clock), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .timer_underflow(timer_underflow), .tx_end(misc[1]),
		.rx_end(misc[2]), .rx_sof(misc[3]), .card_detect(misc[0]),
		.comm_error_bits(comm_error_bits), .cmd_code(cmd_code), .fifo_count(fifo_count),
		.irq_pin(irq_pin));
	ric_host_mdl host (.clock(clock), .irq_pin(irq_pin), .irq_count(hits));
	// ==========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] rst_val(input logic [3:0] a);
		return (a == OFS_LEVEL) ? LEVEL_RST : RDATA_ZERO;
	endfunction
	function automatic logic [7:0] setclr(input logic [7:0] o, input logic [7:0] w);
		return w[7] ? (o | {1'b0, w[6:0]}) : (o & ~{1'b0, w[6:0]});
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] w);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, x);
	endtask
	task automatic ev(input logic [3:0] t, input logic [7:0] c, input logic [3:0] m);
		timer_underflow <= t;
		comm_error_bits <= c;
		misc <= m;
		@(posedge clock);
		timer_underflow <= 4'h0;
		comm_error_bits <= 8'h00;
		misc <= 4'h0;
		#1;
	endtask
	task automatic conclude;
		if (mismatches == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clock);
		mismatches++;
		conclude();
	end
	// ==========
	// Scenarios
	initial begin
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		for (int a = 0; a < 16; a++) rd(4'(a), rst_val(4'(a)));
		wr(OFS_ENABLE_A, 8'hFF);
		rd(OFS_ENABLE_A, 8'h7F);
		en[0] = 8'h7F;
		en[1] = 8'h00;
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			wr(4'(OFS_ENABLE_A + seed[8]), seed[7:0]);
			en[seed[8]] = setclr(en[seed[8]], seed[7:0]);
			rd(4'(OFS_ENABLE_A + seed[8]), en[seed[8]]);
		end
		wr(OFS_ENABLE_A, 8'h7F);
		wr(OFS_ENABLE_B, 8'h7F);
		for (int k = 0; k < 2; k++) begin
			wr(4'(k), 8'hFF);
			rd(4'(k), 8'h7F);
			wr(4'(k), 8'h7F);
			rd(4'(k), 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			ev(4'h1 << i, 8'h00, 4'h0);
			rd(OFS_FLAGS_B, 8'h01 << i);
			wr(OFS_FLAGS_B, 8'h7F);
		end
		seed = lfsr(seed);
		ev(4'h0, seed[7:0] | 8'h01, 4'hF);
		rd(OFS_FLAGS_A, 8'h0F);
		rd(OFS_FLAGS_B, 8'h10);
		wr(OFS_FLAGS_A, 8'h7F);
		wr(OFS_FLAGS_B, 8'h7F);
		cmd_code <= 4'h3;
		@(posedge clock);
		cmd_code <= CMD_IDLE;
		@(posedge clock);
		#1;
		rd(OFS_FLAGS_A, 8'h10);
		fifo_count <= 10'(LEVEL_RST);
		@(posedge clock);
		fifo_count <= 10'(512 - LEVEL_RST);
		@(posedge clock);
		fifo_count <= 10'h064;
		#1;
		rd(OFS_FLAGS_A, 8'h70);
		wr(OFS_FLAGS_A, 8'h7F);
		wr(OFS_LEVEL, 8'h70);
		rd(OFS_LEVEL, 8'h70);
		wr(OFS_LEVEL, LEVEL_RST);
		rd(OFS_FLAGS_A, 8'h20);
		wr(OFS_FLAGS_A, 8'h7F);
		wr(OFS_CTRL, 8'h01);
		rd(OFS_CTRL, 8'h01);
		wr(OFS_ENABLE_B, 8'h81);
		ev(4'h1, 8'h00, 4'h0);
		repeat (3) @(posedge clock);
		#1;
		chk({7'h00, irq_pin}, 8'h01);
		rd(OFS_FLAGS_B, 8'h41);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_CTRL, 8'h00);
		repeat (2) @(posedge clock);
		#1;
		chk({7'h00, irq_pin}, 8'h00);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_FLAGS_B, 8'h7F);
		wr(OFS_FLAGS_B, 8'h7F);
		repeat (3) @(posedge clock);
		#1;
		rd(OFS_STATUS, 8'h00);
		wr(OFS_ENABLE_B, 8'h01);
		wr(OFS_CTRL, 8'h01);
		ev(4'h1, 8'h00, 4'h0);
		repeat (3) @(posedge clock);
		#1;
		chk({7'h00, irq_pin}, 8'h00);
		rd(OFS_FLAGS_B, 8'h01);
		chk(hits, 8'h01);
		conclude();
	end
endmodule // tb_top
